// ==== design/ccpu_pkg.sv ====
// Purpose: Constants for the capture/compare/PWM unit
// Assumes: APB slave, 32-bit data, byte registers in low bits
// Notes:   Offsets are byte addresses (index times four)
`default_nettype none
package ccpu_pkg;
    // Register indices and byte addresses
    localparam logic [7:0]  IDX_MODE_CTRL  = 8'h17;
    localparam logic [7:0]  IDX_CC_LOW     = 8'h15;
    localparam logic [7:0]  IDX_CC_HIGH    = 8'h16;
    localparam logic [7:0]  IDX_FLAGS      = 8'h0c;
    localparam logic [7:0]  IDX_TIMER_LOW  = 8'h0e;
    localparam logic [7:0]  IDX_TIMER_HIGH = 8'h0f;
    localparam logic [7:0]  IDX_CTRL_AUX   = 8'h18;
    localparam logic [11:0] ADDR_MODE_CTRL  = {2'h0, IDX_MODE_CTRL, 2'h0};
    localparam logic [11:0] ADDR_CC_LOW     = {2'h0, IDX_CC_LOW, 2'h0};
    localparam logic [11:0] ADDR_CC_HIGH    = {2'h0, IDX_CC_HIGH, 2'h0};
    localparam logic [11:0] ADDR_FLAGS      = {2'h0, IDX_FLAGS, 2'h0};
    localparam logic [11:0] ADDR_TIMER_LOW  = {2'h0, IDX_TIMER_LOW, 2'h0};
    localparam logic [11:0] ADDR_TIMER_HIGH = {2'h0, IDX_TIMER_HIGH, 2'h0};
    localparam logic [11:0] ADDR_CTRL_AUX   = {2'h0, IDX_CTRL_AUX, 2'h0};
    // Field positions
    localparam int DUTY_LSB_POS   = 4;
    localparam int EVENT_FLAG_POS = 2;
    localparam int TOVF_FLAG_POS  = 0;
    localparam int AUX_TIMER_ON   = 0;
    localparam int AUX_ADC_EN     = 1;
    localparam int AUX_PIN_OUTPUT = 2;
    localparam int AUX_PORT_DATA  = 3;
    // Reset values, masks and prescaler match values
    localparam logic [7:0] MODE_CTRL_RESET = 8'h00;
    localparam logic [7:0] MODE_CTRL_MASK  = 8'h3f;
    localparam logic [3:0] PRESC_FOURTH    = 4'h3;
    localparam logic [3:0] PRESC_SIXTEENTH = 4'hf;
    // Mode field encodings
    localparam logic [3:0] MODE_OFF       = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL  = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE  = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16= 4'h7;
    localparam logic [3:0] MODE_CMP_SET   = 4'h8;
    localparam logic [3:0] MODE_CMP_CLR   = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT  = 4'ha;
    localparam logic [3:0] MODE_CMP_SPEC  = 4'hb;
endpackage
`default_nettype wire

// ==== design/ccpu_top.sv ====
// Purpose: Capture/compare/PWM unit with its own timer, APB registers
// Assumes: Pin input synchronous to pclk; single clock domain
// Notes:   PWM period generation is not part of this unit
// Notes on behaviour
// [R1] Word from two bytes; all read/write
// [R2] Sixteen-bit timer bases capture and compare
// [R3] Mode zero turns unit off, resets
// [R4] Modes four to seven pick capture edge
// [R5] Mode 1000 drives output high, flag
// [R6] Mode 1001 drives output low, flag
// [R7] Mode 1010 sets flag only
// [R8] Mode 1011 resets timer, starts conversion
// [R9] Modes 11xx are PWM with duty bits
// [R10] Capture event chosen by bits three-zero
// [R11] Capture copies whole timer into bytes
// [R12] Capture sets event flag
// [R13] Software clears flag; hardware holds it
// [R14] New capture overwrites without overrun
// [R15] Software makes pin an input
// [R16] Port write on output pin captures
// [R17] Prescaler cleared unless in capture mode
// [R18] Special trigger never sets overflow flag
// [R19] Timer must run synchronised for capture
// [R20] Pin synchronised; capture same cycle
// [R21] New mode acts next clock
`default_nettype none
module ccpu_top
    import ccpu_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Pin and system
    input  wire logic        unit_pin_in,
    input  wire logic        pwm_duty_match,
    output logic             unit_pin_out,
    output logic             unit_pin_oe_n,
    output logic             adc_start,
    output logic [9:0]       pwm_duty
);
    import ccpu_pkg::*;

    typedef struct packed {
        logic [7:0]  mode_ctrl;
        logic [7:0]  cc_low;
        logic [7:0]  cc_high;
        logic [15:0] timer;
        logic        event_flag;
        logic        tovf_flag;
        logic [3:0]  aux;
        logic [3:0]  presc;
        logic        sync1;
        logic        sync2;
        logic        pin_prev;
        logic        cmp_out;
        logic        pin_out;
        logic        adc_start;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ccpu_state_t;

    ccpu_state_t s_r;
    ccpu_state_t s_nxt;

    logic [3:0] mode;
    logic       capture_mode;
    logic       pin_level;
    logic       rise;
    logic       fall;
    logic       cap_event;
    logic       match;
    logic       wr;
    logic       rd;
    logic       addr_ok;

    // Decode of mode and pin edges; pin level muxed when driven by port
    always_comb begin
        // [R10] Event type from bits three to zero
        mode         = s_r.mode_ctrl[3:0];
        capture_mode = (mode[3:2] == 2'b01);
        // [R16] Port write edge
        pin_level = s_r.aux[AUX_PIN_OUTPUT] ? s_r.aux[AUX_PORT_DATA]
                                            : s_r.sync2;
        rise      = pin_level & ~s_r.pin_prev;
        fall      = ~pin_level & s_r.pin_prev;
        match     = ({s_r.cc_high, s_r.cc_low} == s_r.timer);
        // Writes land at the edge where the master sees pready high
        wr = psel & penable & s_r.pready & pwrite;
        rd = psel & penable & ~s_r.pready & ~pwrite;
        addr_ok = (paddr == ADDR_MODE_CTRL) || (paddr == ADDR_CC_LOW) ||
                  (paddr == ADDR_CC_HIGH) || (paddr == ADDR_FLAGS) ||
                  (paddr == ADDR_TIMER_LOW) ||
                  (paddr == ADDR_TIMER_HIGH) || (paddr == ADDR_CTRL_AUX);
    end

    // [R4] Capture event select
    always_comb begin
        unique case (mode)
            MODE_CAP_FALL:   cap_event = fall;
            MODE_CAP_RISE:   cap_event = rise;
            MODE_CAP_RISE4:
                cap_event = rise && (s_r.presc[1:0] == PRESC_FOURTH[1:0]);
            MODE_CAP_RISE16: cap_event = rise && (s_r.presc == PRESC_SIXTEENTH);
            default:         cap_event = 1'b0;
        endcase
    end

    // Next-state logic: timer step before bus writes, capture and compare after so their set wins
    always_comb begin
        s_nxt = s_r;
        // [R20] Two-stage pin synchroniser
        s_nxt.sync1     = unit_pin_in;
        s_nxt.sync2     = s_r.sync1;
        s_nxt.pin_prev  = pin_level;
        s_nxt.adc_start = 1'b0;
        // [R2] Timer base runs when enabled
        if (s_r.aux[AUX_TIMER_ON]) begin
            s_nxt.timer = s_r.timer + 16'h0001;
            if (s_r.timer == 16'hffff) begin
                s_nxt.tovf_flag = 1'b1;
            end
        end
        // [R17] Prescale counter only counts in capture mode
        if (capture_mode) begin
            if (rise) begin
                s_nxt.presc = s_r.presc + 4'h1;
            end
        end else begin
            s_nxt.presc = 4'h0;
        end
        // APB access phase completes in one wait cycle
        s_nxt.pready  = psel & penable & ~s_r.pready;
        s_nxt.pslverr = psel & penable & ~s_r.pready & ~addr_ok;
        s_nxt.prdata  = 32'h0000_0000;
        if (rd) begin
            unique case (paddr)
                // [R1] Bytes and control readable
                ADDR_MODE_CTRL:  s_nxt.prdata[7:0] = s_r.mode_ctrl;
                ADDR_CC_LOW:     s_nxt.prdata[7:0] = s_r.cc_low;
                ADDR_CC_HIGH:    s_nxt.prdata[7:0] = s_r.cc_high;
                ADDR_FLAGS: begin
                    s_nxt.prdata[EVENT_FLAG_POS] = s_r.event_flag;
                    s_nxt.prdata[TOVF_FLAG_POS]  = s_r.tovf_flag;
                end
                ADDR_TIMER_LOW:  s_nxt.prdata[7:0] = s_r.timer[7:0];
                ADDR_TIMER_HIGH: s_nxt.prdata[7:0] = s_r.timer[15:8];
                ADDR_CTRL_AUX:   s_nxt.prdata[3:0] = s_r.aux;
                default:         s_nxt.prdata = 32'h0000_0000;
            endcase
        end
        if (wr) begin
            unique case (paddr)
                // [R21] Mode write acts next clock
                ADDR_MODE_CTRL:
                    s_nxt.mode_ctrl = pwdata[7:0] & MODE_CTRL_MASK;
                // [R1] Bytes writable
                ADDR_CC_LOW:     s_nxt.cc_low = pwdata[7:0];
                ADDR_CC_HIGH:    s_nxt.cc_high = pwdata[7:0];
                // [R13] Software clears flags
                ADDR_FLAGS: begin
                    s_nxt.event_flag = pwdata[EVENT_FLAG_POS];
                    s_nxt.tovf_flag  = pwdata[TOVF_FLAG_POS];
                end
                ADDR_TIMER_LOW:  s_nxt.timer[7:0] = pwdata[7:0];
                ADDR_TIMER_HIGH: s_nxt.timer[15:8] = pwdata[7:0];
                ADDR_CTRL_AUX:   s_nxt.aux = pwdata[3:0];
                default:         s_nxt.aux = s_nxt.aux;
            endcase
        end
        // [R11] Capture copies timer; [R14] overwrite silently
        if (cap_event) begin
            s_nxt.cc_low  = s_r.timer[7:0];
            s_nxt.cc_high = s_r.timer[15:8];
            // [R12] Flag on capture
            s_nxt.event_flag = 1'b1;
        end
        // Compare actions; timer write has precedence over the trigger
        if (match && (mode[3:2] == 2'b10)) begin
            s_nxt.event_flag = 1'b1;
            unique case (mode)
                // [R5] Output high
                MODE_CMP_SET: s_nxt.cmp_out = 1'b1;
                // [R6] Output low
                MODE_CMP_CLR: s_nxt.cmp_out = 1'b0;
                // [R7] Flag only
                MODE_CMP_SOFT: s_nxt.cmp_out = s_r.cmp_out;
                // [R8] Timer reset and conversion; [R18] no overflow flag
                MODE_CMP_SPEC: begin
                    if (!(wr && (paddr == ADDR_TIMER_LOW ||
                                 paddr == ADDR_TIMER_HIGH))) begin
                        s_nxt.timer = 16'h0000;
                        s_nxt.tovf_flag = (wr && paddr == ADDR_FLAGS) ?
                            pwdata[TOVF_FLAG_POS] : s_r.tovf_flag;
                    end
                    s_nxt.adc_start = s_r.aux[AUX_ADC_EN];
                end
                default: s_nxt.cmp_out = s_r.cmp_out;
            endcase
        end
        // [R3] Mode zero clears compare output and prescaler
        if (mode == MODE_OFF) begin
            s_nxt.cmp_out = 1'b0;
            s_nxt.presc   = 4'h0;
        end
        // Pin driver registered so the output leaves a flip-flop
        s_nxt.pin_out = (mode[3:2] == 2'b11) ? pwm_duty_match
                                             : s_nxt.cmp_out;
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flip-flops
    always_comb begin
        prdata        = s_r.prdata;
        pready        = s_r.pready;
        pslverr       = s_r.pslverr;
        unit_pin_out  = s_r.pin_out;
        unit_pin_oe_n = ~s_r.aux[AUX_PIN_OUTPUT];
        adc_start     = s_r.adc_start;
        // [R9] PWM duty from low byte and two field bits
        pwm_duty = {s_r.cc_low,
                    s_r.mode_ctrl[DUTY_LSB_POS+1:DUTY_LSB_POS]};
    end

    // Checks on the state register; all sampled on pclk, off in reset

    // Capture must set the flag next cycle
    a_capture_flag: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        cap_event |=> s_r.event_flag)
        else $error("capture flag missing");

    // Captured word is the timer of the event cycle
    a_capture_copy: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        cap_event |=> {s_r.cc_high, s_r.cc_low} == $past(s_r.timer))
        else $error("capture value wrong");

    // Prescaler held at zero outside capture modes
    a_off_presc: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
        !capture_mode |=> s_r.presc == 4'h0)
        else $error("prescaler not cleared");

    // Set-on-match drives the output high
    a_cmp_set: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
        (match && mode == MODE_CMP_SET) |=> s_r.cmp_out)
        else $error("compare set failed");

    // Clear-on-match drives the output low
    a_cmp_clr: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        (match && mode == MODE_CMP_CLR) |=> !s_r.cmp_out)
        else $error("compare clear failed");

    // Flag-only compare leaves the output alone
    a_cmp_soft: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
        (match && mode == MODE_CMP_SOFT) |=> $stable(s_r.cmp_out))
        else $error("soft compare touched pin");

    // Special trigger clears timer and may start a conversion
    a_special_evt: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        (match && mode == MODE_CMP_SPEC && !wr) |=>
        s_r.timer == 16'h0000 && adc_start == $past(s_r.aux[AUX_ADC_EN]))
        else $error("special trigger failed");

    // Unit off forces the compare latch low
    a_mode_off: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
        (mode == MODE_OFF) |=> !s_r.cmp_out)
        else $error("off mode left output");

    // Ready is a single-cycle answer
    a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        s_r.pready |=> !s_r.pready)
        else $error("ready held too long");

    // Unmapped access is answered with an error
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        (psel && penable && !s_r.pready && !addr_ok) |=> s_r.pslverr)
        else $error("unmapped access not flagged");

    // Low byte takes the written data
    a_write_low: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        (wr && paddr == ADDR_CC_LOW && !cap_event) |=>
        s_r.cc_low == $past(pwdata[7:0]))
        else $error("low byte write lost");

    // High byte takes the written data
    a_write_high: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
        (wr && paddr == ADDR_CC_HIGH && !cap_event) |=>
        s_r.cc_high == $past(pwdata[7:0]))
        else $error("high byte write lost");

    // Mode write is in force from the next clock
    a_mode_write: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
        (wr && paddr == ADDR_MODE_CTRL) |=>
        s_r.mode_ctrl == ($past(pwdata[7:0]) & MODE_CTRL_MASK))
        else $error("mode write late");

    // Running timer steps by one each clock
    a_timer_run: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        (s_r.aux[AUX_TIMER_ON] && !wr && !(match && mode == MODE_CMP_SPEC))
        |=> s_r.timer == $past(s_r.timer) + 16'h0001)
        else $error("timer did not count");

    // Flag stays until software writes it
    a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R13]
        (s_r.event_flag && !wr) |=> s_r.event_flag)
        else $error("event flag dropped");

    // Hardware set beats a clear in the same cycle
    a_set_wins: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
        (cap_event && wr && paddr == ADDR_FLAGS) |=> s_r.event_flag)
        else $error("clear beat capture");

    // Capture word is kept between events
    a_keep_word: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
        (capture_mode && !cap_event && !wr) |=>
        $stable({s_r.cc_high, s_r.cc_low}))
        else $error("capture word changed");

    // Special trigger never raises the overflow flag
    a_trig_no_ovf: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
        (match && mode == MODE_CMP_SPEC && !wr) |=> !$rose(s_r.tovf_flag))
        else $error("trigger set overflow");

    // No conversion start while the converter is disabled
    a_adc_gate: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        !s_r.aux[AUX_ADC_EN] |=> !adc_start)
        else $error("conversion while disabled");

    // Timer write beats the trigger reset
    a_timer_wins: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
        (wr && paddr == ADDR_TIMER_LOW && match && mode == MODE_CMP_SPEC)
        |=> s_r.timer[7:0] == $past(pwdata[7:0]))
        else $error("trigger beat timer write");

    // PWM level reaches the pin one clock later
    a_pwm_pin: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
        (mode[3:2] == 2'b11) |=> unit_pin_out == $past(pwm_duty_match))
        else $error("pwm level not passed");

    // Pin level passes two synchroniser stages
    a_sync_delay: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
        s_r.sync2 == $past(unit_pin_in, 2))
        else $error("synchroniser delay wrong");
endmodule
`default_nettype wire

// ==== testbench/ccpu_pin_source.sv ====
// Purpose: External signal source on the unit pin
// Assumes: Pin level is made in the pclk domain
// Notes:   Idle low; every pulse gives one rise and one fall
`default_nettype none
module ccpu_pin_source (
    // Clock and pin
    input  wire logic clk,
    output var  logic pin
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle level before any pulse
    initial pin = 1'b0;

    // pin as input, clocked source
    // Settle time covers the two-flop synchroniser
    task automatic pulse(input int width);
        @(posedge clk);
        pin <= 1'b1;
        repeat (width) @(posedge clk);
        pin <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ==== testbench/ccpu_tb_top.sv ====
// Purpose: Self-checking bench for the capture/compare/PWM unit
// Assumes: Timer stays stopped so captured values are known
// Notes:   Expected values come from a mirror of the written bytes
`default_nettype none
module ccpu_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ccpu_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pwm_duty_match;
    logic        pready, pslverr, unit_pin_in, unit_pin_out, unit_pin_oe_n;
    logic        adc_start, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, rnd;
    logic [9:0]  pwm_duty;
    logic [15:0] tval;
    int          n_fail, n_checks, n_adc;
    int          need[4] = '{1, 1, 4, 16};
    logic [1:0]  pin_exp[3] = '{2'b01, 2'b00, 2'b00};

    // Clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    ccpu_top i_ccpu_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .unit_pin_in(unit_pin_in), .pwm_duty_match(pwm_duty_match),
        .unit_pin_out(unit_pin_out), .unit_pin_oe_n(unit_pin_oe_n),
        .adc_start(adc_start), .pwm_duty(pwm_duty));
    ccpu_pin_source i_ccpu_pin_source (.clk(pclk), .pin(unit_pin_in));

    // Count conversion start pulses
    always @(posedge pclk) begin
        if (adc_start === 1'b1) n_adc++;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // One APB transfer; waits for pready, only the watchdog ends a hang
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic set_timer(input logic [15:0] v);
        apb(1'b1, ADDR_TIMER_LOW, {24'h0, v[7:0]});
        apb(1'b1, ADDR_TIMER_HIGH, {24'h0, v[15:8]});
    endtask

    task automatic chk_flag(input string nm, input logic [31:0] e);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        chk(nm, e, rd & 32'h4);
    endtask

    task automatic chk_cap(input logic [15:0] v);
        logic [7:0] lo;
        apb(1'b0, ADDR_CC_LOW, 32'h0);
        lo = rd[7:0];
        apb(1'b0, ADDR_CC_HIGH, 32'h0);
        chk("capture", {16'h0, v}, {16'h0, rd[7:0], lo});
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles of the run
    initial begin
        #200us;
        n_fail++;
        final_report;
    end

    initial begin
        rnd = 32'hdec477c4;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h0; pwdata = 32'h0; pwm_duty_match = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ADDR_MODE_CTRL, 32'h0);
        chk("mode_reset", 32'h0, rd);
        chk("pin_oe_n", 32'h1, {31'h0, unit_pin_oe_n});
        apb(1'b0, 12'hffc, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        rnd = lfsr(rnd);
        apb(1'b1, ADDR_CC_LOW, {24'h0, rnd[7:0]});
        apb(1'b1, ADDR_CC_HIGH, {24'h0, rnd[15:8]});
        apb(1'b1, ADDR_MODE_CTRL, 32'hff);
        chk_cap(rnd[15:0]);
        apb(1'b0, ADDR_MODE_CTRL, 32'h0);
        chk("mode_rw", 32'h3f, rd);
        chk("duty", {22'h0, rnd[7:0], 2'b11}, {22'h0, pwm_duty});
        pwm_duty_match <= rnd[16];
        repeat (2) @(posedge pclk);
        chk("pwm_pin", {31'h0, rnd[16]}, {31'h0, unit_pin_out});
        // Every capture mode: no event one pulse early, event on time
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, ADDR_MODE_CTRL, 32'h0);
            rnd = lfsr(rnd);
            tval = rnd[15:0];
            set_timer(tval);
            apb(1'b1, ADDR_FLAGS, 32'h0);
            apb(1'b1, ADDR_MODE_CTRL, 32'h4 + m);
            repeat (need[m] - 1) i_ccpu_pin_source.pulse(2 + rnd[17:16]);
            chk_flag("early", 32'h0);
            i_ccpu_pin_source.pulse(2);
            chk_flag("event", 32'h4);
            chk_cap(tval);
        end
        apb(1'b1, ADDR_MODE_CTRL, 32'h5);
        tval = tval ^ 16'h5a5a;
        set_timer(tval);
        i_ccpu_pin_source.pulse(3);
        chk_cap(tval);
        chk_flag("held", 32'h4);
        apb(1'b1, ADDR_FLAGS, 32'h0);
        chk_flag("cleared", 32'h0);
        // Port write on an output pin counts as an edge
        apb(1'b1, ADDR_CTRL_AUX, 32'h4);
        tval = tval + 16'h0101;
        set_timer(tval);
        chk("pin_oe_n", 32'h0, {31'h0, unit_pin_oe_n});
        apb(1'b1, ADDR_CTRL_AUX, 32'hc);
        repeat (6) @(posedge pclk);
        chk_flag("port_cap", 32'h4);
        chk_cap(tval);
        // Compare modes; pin output lags the match by one register
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, ADDR_FLAGS, 32'h0);
            apb(1'b1, ADDR_MODE_CTRL, 32'h8 + m);
            repeat (3) @(posedge pclk);
            chk("cmp_pin", {31'h0, pin_exp[m][0]},
                {31'h0, unit_pin_out});
            chk_flag("cmp_flag", 32'h4);
        end
        apb(1'b1, ADDR_FLAGS, 32'h0);
        apb(1'b1, ADDR_CTRL_AUX, 32'h6);
        apb(1'b1, ADDR_MODE_CTRL, 32'hb);
        repeat (3) @(posedge pclk);
        apb(1'b0, ADDR_TIMER_HIGH, 32'h0);
        chk("timer_rst", 32'h0, rd);
        apb(1'b0, ADDR_FLAGS, 32'h0);
        chk("trig_flags", 32'h4, rd & 32'h5);
        chk("adc_start", 32'h1, n_adc);
        final_report;
    end
endmodule
`default_nettype wire
